//--- rtl/pbm_bank.sv
// management register bank with serial management port on its own clock
// Summary of operation
// [R01] management clock is at most 12.5 MHz; data sampled on its edges
// [R02] control bit 15 starts a soft reset and clears itself when done
// [R03] control bit 14 enables loopback, default 0, cleared by soft reset
// [R04] speed pair bits 13 and 6 apply only while negotiation is off
// [R05] speed pair 00 means 10 Mb/s, 01 means 100 Mb/s, others unsupported
// [R06] control bit 12 enables negotiation, default 1
// [R07] bit 11 powers down; clearing it causes soft reset and restart
// [R08] bit 10 isolates: mac inputs ignored, receive outputs undriven
// [R09] bit 9 restarts negotiation and self clears; resets also restart
// [R10] bit 8 selects full duplex when negotiation is off, default 1
// [R11] bit 7 makes collision follow transmit enable
// [R12] status ability bits read constant values
// [R13] preamble-less frames accepted; status bit 6 reads 1
// [R14] status bit 5 shows negotiation done, cleared by soft reset
// [R15] status bit 4 latches remote fault until read or soft reset
// [R16] status bit 2 latches link loss low until read
// [R17] status bit 1 latches jabber in 10 Mb/s until read
// [R18] identifier words return oui bits, model and revision
// [R19] advertisement writes store at once, used after restart events
// [R20] software keeps advertisement bit 15 low without more pages
// [R21] advertisement bits 13 to 10 with their defaults
// [R22] advertisement bits 8 to 5 default 1; bit 9 reads 0
// [R23] selector field defaults to 00001
// [R24] partner ability bit 15 shows partner next page, soft reset clears
// [R25] standard serial frame; device drives only in read turnaround/data
module pbm_bank
  import pbm_pkg::*;
#(
  parameter logic [15:0] OUI_HIGH = 16'h0A5C, // arbitrary value
  parameter logic [5:0]  OUI_LOW  = 6'h2B,    // arbitrary value
  parameter logic [5:0]  MODEL    = 6'h05,    // arbitrary value
  parameter logic [3:0]  REVISION = 4'h3,     // arbitrary value
  parameter logic [4:0]  PHY_ADDR = 5'h01
)(
  input  wire logic        clk_sys,
  input  wire logic        reset,
  input  wire logic        clk_en,
  input  wire logic        mdc,
  input  wire logic        mdio_in,
  output logic             mdio_out,
  output logic             mdio_oe,
  input  wire logic        neg_done,
  input  wire logic        remote_fault,
  input  wire logic        link_up,
  input  wire logic        jabber,
  input  wire logic [15:0] partner_word,
  input  wire logic        mac_tx_en,
  output logic             col_out,
  output logic             rx_oe,
  output logic             tx_en_eff,
  output logic             loopback,
  output logic             speed_100,
  output logic             speed_bad,
  output logic             full_duplex,
  output logic             neg_enable,
  output logic             power_down,
  output logic             neg_restart,
  output logic             soft_reset,
  output logic [15:0]      adv_active
);
  // ---------------- link side, clocked by mdc ----------------
  pbm_state_e  st_r;
  logic [3:0]  cnt_r;
  logic [1:0]  op_r;
  logic [9:0]  head_r;
  logic [15:0] sh_r;
  logic        ok_r;
  logic        wr_tog_r;
  logic        rd_tog_r;
  logic [4:0]  wr_addr_r;
  logic [15:0] wr_data_r;
  logic [4:0]  rd_addr_r;
  logic [1:0]  sb_r;
  logic [15:0] rd_word;
  logic [15:0] rd_hold_r;

  // frame decoder; preamble optional, start 01 seen from idle [R13] [R25]
  always_ff @(posedge mdc or posedge reset) begin // [R01]
    if (reset) begin
      st_r   <= PBM_IDLE;
      cnt_r  <= 4'h0;
      op_r   <= 2'b00;
      head_r <= 10'h000;
      sb_r   <= 2'b11;
    end else begin
      sb_r <= {sb_r[0], mdio_in};
      case (st_r)
        PBM_IDLE: if (sb_r[0] && !mdio_in) st_r <= PBM_START;
        PBM_START: begin
          if (mdio_in) begin
            st_r  <= PBM_HEAD;
            cnt_r <= 4'h0;
          end else st_r <= PBM_IDLE;
        end
        PBM_HEAD: begin
          if (cnt_r < 4'd2) op_r <= {op_r[0], mdio_in};
          else head_r <= {head_r[8:0], mdio_in};
          cnt_r <= cnt_r + 4'h1;
          if (cnt_r == 4'd11) begin
            st_r  <= PBM_TA;
            cnt_r <= 4'h0;
          end
        end
        PBM_TA: begin
          cnt_r <= cnt_r + 4'h1;
          if (cnt_r == 4'd1) begin
            st_r  <= PBM_DATA;
            cnt_r <= 4'h0;
          end
        end
        PBM_DATA: begin
          cnt_r <= cnt_r + 4'h1;
          if (cnt_r == 4'd15) st_r <= PBM_IDLE;
        end
        default: st_r <= PBM_IDLE;
      endcase
    end
  end

  wire addr_hit = (head_r[9:5] == PHY_ADDR);

  // read request raised at end of header, answered in turnaround
  always_ff @(posedge mdc or posedge reset) begin
    if (reset) begin
      rd_tog_r  <= 1'b0;
      rd_addr_r <= 5'h00;
      wr_tog_r  <= 1'b0;
      wr_addr_r <= 5'h00;
      wr_data_r <= 16'h0000;
      ok_r      <= 1'b0;
    end else begin
      if (st_r == PBM_TA && cnt_r == 4'd0) begin
        ok_r <= addr_hit && (op_r == OP_READ);
        if (addr_hit && op_r == OP_READ) begin
          rd_tog_r  <= ~rd_tog_r;
          rd_addr_r <= head_r[4:0];
        end
      end
      if (st_r == PBM_DATA && cnt_r == 4'd15 && addr_hit &&
          op_r == OP_WRITE) begin
        wr_tog_r  <= ~wr_tog_r;
        wr_addr_r <= head_r[4:0];
        wr_data_r <= {sh_r[14:0], mdio_in};
      end
      if (st_r == PBM_IDLE) ok_r <= 1'b0;
    end
  end

  // output shifter: device drives in second turnaround bit and data [R25]
  always_ff @(negedge mdc or posedge reset) begin
    if (reset) begin
      mdio_oe  <= 1'b0;
      mdio_out <= 1'b0;
    end else if (ok_r && st_r == PBM_TA) begin
      mdio_oe  <= 1'b1; // [R25]
      mdio_out <= 1'b0;
    end else if (ok_r && st_r == PBM_DATA) begin
      mdio_oe  <= 1'b1;
      mdio_out <= sh_r[15];
    end else begin
      mdio_oe  <= 1'b0;
      mdio_out <= 1'b0;
    end
  end

  // sh_r: loaded with the held read word at end of turnaround, shifts data
  // every data edge moves the next bit up for the following falling edge
  always_ff @(posedge mdc or posedge reset) begin
    if (reset) sh_r <= 16'h0000;
    else if (st_r == PBM_TA && cnt_r == 4'd1) sh_r <= rd_hold_r;
    else if (st_r == PBM_DATA && !ok_r) sh_r <= {sh_r[14:0], mdio_in};
    else if (st_r == PBM_DATA) sh_r <= {sh_r[14:0], 1'b0};
  end

  // ---------------- system side ----------------
  logic [2:0]  wsync_r;
  logic [2:0]  rsync_r;
  logic [15:0] ctl_r;
  logic [15:0] adv_r;
  logic [15:0] partner_r;
  logic        nd_r, rf_r, lk_r, jb_r;
  logic [SRST_W-1:0] srst_cnt_r;
  logic        rst_req;
  logic        wr_ev, rd_ev, rd_status, pd_exit;
  logic [15:0] sts_word;

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      wsync_r <= 3'b000;
      rsync_r <= 3'b000;
    end else if (clk_en) begin
      wsync_r <= {wsync_r[1:0], wr_tog_r};
      rsync_r <= {rsync_r[1:0], rd_tog_r};
    end
  end
  assign wr_ev = clk_en && (wsync_r[2] != wsync_r[1]);
  assign rd_ev = clk_en && (rsync_r[2] != rsync_r[1]);
  // read address settled long before toggle crossed; registers are stable
  assign rd_status = rd_ev && (rd_addr_r == REG_STATUS);
  wire ctl_wr = wr_ev && (wr_addr_r == REG_CONTROL);
  assign pd_exit = ctl_wr && ctl_r[CTL_POWER_DOWN] &&
                   !wr_data_r[CTL_POWER_DOWN]; // [R07]
  assign rst_req = (ctl_wr && wr_data_r[CTL_SOFT_RESET]) || pd_exit; // [R02]
  assign soft_reset = (srst_cnt_r != '0);

  // soft reset sequencer; bit 15 reads 1 until the sequence ends [R02]
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) srst_cnt_r <= '0;
    else if (clk_en) begin
      if (rst_req) srst_cnt_r <= SRST_W'(SOFT_RESET_CYCLES);
      else if (soft_reset) srst_cnt_r <= srst_cnt_r - 1'b1;
    end
  end

  // control register
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) ctl_r <= CTL_RESET_VAL;
    else if (clk_en) begin
      if (ctl_wr) ctl_r <= wr_data_r & CTL_WMASK;
      else if (soft_reset) begin
        ctl_r[CTL_LOOPBACK]   <= 1'b0; // [R03]
        ctl_r[CTL_POWER_DOWN] <= 1'b0;
        ctl_r[CTL_ISOLATE]    <= 1'b0; // [R08]
        ctl_r[CTL_COL_TEST]   <= 1'b0; // [R11]
        ctl_r[CTL_NEG_RESTART] <= 1'b0;
        if (srst_cnt_r == SRST_W'(1)) ctl_r[CTL_SOFT_RESET] <= 1'b0; // [R02]
      end else ctl_r[CTL_NEG_RESTART] <= 1'b0; // [R09]
      if (rst_req) ctl_r[CTL_SOFT_RESET] <= 1'b1;
    end
  end

  // restart pulse: hardware reset, write of bit 9, soft reset, power-down exit [R09]
  logic boot_r;
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      neg_restart <= 1'b0;
      boot_r      <= 1'b1;
      adv_active  <= ADV_RESET_VAL;
    end else if (clk_en) begin
      boot_r      <= 1'b0;
      neg_restart <= boot_r || rst_req ||
                     (ctl_wr && wr_data_r[CTL_NEG_RESTART]); // [R09] [R07]
      if (neg_restart || (lk_r && !link_up))
        adv_active <= adv_r; // [R19]
    end
  end

  // advertisement register; bits 14 and 9 read 0 [R21] [R22] [R23]
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) adv_r <= ADV_RESET_VAL;
    else if (clk_en && wr_ev && wr_addr_r == REG_ADVERTISE)
      adv_r <= wr_data_r & ADV_WMASK; // [R19] [R20]
  end

  // latched status bits; an event in the read cycle wins over the clear
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      nd_r <= 1'b0;
      rf_r <= 1'b0;
      lk_r <= 1'b0;
      jb_r <= 1'b0;
      partner_r <= 16'h0000;
    end else if (clk_en) begin
      if (soft_reset) begin
        nd_r <= 1'b0; // [R14]
        rf_r <= 1'b0; // [R15]
        lk_r <= 1'b0; // [R16]
        jb_r <= 1'b0; // [R17]
        partner_r <= 16'h0000; // [R24]
      end else begin
        nd_r <= neg_done; // [R14]
        rf_r <= remote_fault || (rf_r && !rd_status); // [R15]
        jb_r <= (jabber && !speed_100) || (jb_r && !rd_status); // [R17]
        if (!link_up) lk_r <= 1'b0; // [R16]
        else if (rd_status) lk_r <= 1'b1;
        partner_r <= partner_word; // [R24]
      end
    end
  end

  assign sts_word = STS_CONST | {10'h000, nd_r, rf_r, 1'b0, lk_r, jb_r,
                                 1'b0}; // [R12] [R13]

  // read mux; the status word is taken before its read clears latches
  always_comb begin
    case (rd_addr_r)
      REG_CONTROL:   rd_word = ctl_r;
      REG_STATUS:    rd_word = sts_word;
      REG_ID_HIGH:   rd_word = OUI_HIGH; // [R18]
      REG_ID_LOW:    rd_word = {OUI_LOW, MODEL, REVISION}; // [R18]
      REG_ADVERTISE: rd_word = adv_r;
      REG_PARTNER:   rd_word = partner_r;
      default:       rd_word = 16'h0000;
    endcase
  end

  // read word held from the cycle the request crosses; the mdc side loads
  // it about one mdc period later, while it stands still [R15] [R16] [R17]
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) rd_hold_r <= 16'h0000;
    else if (rd_ev) rd_hold_r <= rd_word;
  end

  // effective modes
  always_comb begin
    neg_enable  = ctl_r[CTL_NEG_ENABLE]; // [R06]
    loopback    = ctl_r[CTL_LOOPBACK]; // [R03]
    power_down  = ctl_r[CTL_POWER_DOWN]; // [R07]
    // negotiated results assumed 100/full whenever negotiation is enabled
    speed_100   = neg_enable ? 1'b1 :
                  ({ctl_r[CTL_SPEED_HI], ctl_r[CTL_SPEED_LO]} == 2'b01);
    speed_bad   = !neg_enable && ctl_r[CTL_SPEED_HI]; // [R04] [R05]
    full_duplex = neg_enable ? 1'b1 : ctl_r[CTL_DUPLEX]; // [R10]
    tx_en_eff   = mac_tx_en && !ctl_r[CTL_ISOLATE]; // [R08]
    rx_oe       = !ctl_r[CTL_ISOLATE]; // [R08]
    col_out     = ctl_r[CTL_COL_TEST] && tx_en_eff; // [R11]
  end

  // system side checks
  a_soft_self_clear: assert property (@(posedge clk_sys) // [R02]
    disable iff (reset)
    clk_en && rst_req ##1 clk_en [*4] |=> !ctl_r[CTL_SOFT_RESET])
    else $error("soft reset bit did not clear");
  a_reset_clears_loop: assert property (@(posedge clk_sys) // [R03]
    disable iff (reset) soft_reset && clk_en && !ctl_wr |=> !loopback)
    else $error("loopback survived soft reset");
  a_speed_decode: assert property (@(posedge clk_sys) // [R05]
    disable iff (reset) !neg_enable |-> speed_100 ==
    (!ctl_r[CTL_SPEED_HI] && ctl_r[CTL_SPEED_LO]) &&
    speed_bad == ctl_r[CTL_SPEED_HI])
    else $error("speed decode wrong");
  a_pd_exit_restart: assert property (@(posedge clk_sys) // [R07]
    disable iff (reset) pd_exit |=> soft_reset && neg_restart)
    else $error("power down exit missed reset");
  a_isolate_rx: assert property (@(posedge clk_sys) // [R08]
    disable iff (reset)
    ctl_r[CTL_ISOLATE] |-> !rx_oe && !tx_en_eff && !col_out)
    else $error("isolate not honoured");
  a_restart_clear: assert property (@(posedge clk_sys) // [R09]
    disable iff (reset)
    clk_en && ctl_r[CTL_NEG_RESTART] && !ctl_wr |=> !ctl_r[CTL_NEG_RESTART])
    else $error("restart bit stuck");
  a_srst_restart: assert property (@(posedge clk_sys) // [R09]
    disable iff (reset) clk_en && rst_req |=> neg_restart)
    else $error("reset did not restart negotiation");
  a_col_follow: assert property (@(posedge clk_sys) // [R11]
    disable iff (reset)
    ctl_r[CTL_COL_TEST] && mac_tx_en && !ctl_r[CTL_ISOLATE] |-> col_out)
    else $error("collision test failed");
  a_srst_flags: assert property (@(posedge clk_sys) // [R14]
    disable iff (reset) clk_en && soft_reset |=> !nd_r && !rf_r &&
    !lk_r && !jb_r && partner_r == 16'h0000) // [R24]
    else $error("soft reset left status set");
  a_fault_latch: assert property (@(posedge clk_sys) // [R15]
    disable iff (reset) clk_en && remote_fault && !soft_reset |=> rf_r)
    else $error("remote fault not latched");
  a_link_low: assert property (@(posedge clk_sys) // [R16]
    disable iff (reset) clk_en && !link_up |=> !lk_r)
    else $error("link loss not latched");
  a_jabber_latch: assert property (@(posedge clk_sys) // [R17]
    disable iff (reset)
    clk_en && jabber && !speed_100 && !soft_reset |=> jb_r)
    else $error("jabber not latched");
  a_adv_apply: assert property (@(posedge clk_sys) // [R19]
    disable iff (reset) clk_en && neg_restart |=> adv_active == $past(adv_r))
    else $error("advertisement not applied");
  // link side checks
  a_mdio_drive: assert property (@(negedge mdc) disable iff (reset) // [R25]
    mdio_oe |-> ok_r)
    else $error("mdio driven outside read");
  a_read_turn: assert property (@(negedge mdc) disable iff (reset) // [R25]
    ok_r && st_r == PBM_TA |=> mdio_oe && !mdio_out)
    else $error("turnaround not driven low");
  c_write: cover property (@(posedge clk_sys) wr_ev);
  c_read: cover property (@(posedge clk_sys) rd_status);
  c_srst: cover property (@(posedge clk_sys) rst_req);
  c_pd: cover property (@(posedge clk_sys) pd_exit);
  c_drive: cover property (@(negedge mdc) mdio_oe);
endmodule

//--- rtl/pbm_pkg.sv
// package for the management register bank: addresses, fields, defaults
package pbm_pkg;
  localparam logic [4:0]  REG_CONTROL   = 5'h00;
  localparam logic [4:0]  REG_STATUS    = 5'h01;
  localparam logic [4:0]  REG_ID_HIGH   = 5'h02;
  localparam logic [4:0]  REG_ID_LOW    = 5'h03;
  localparam logic [4:0]  REG_ADVERTISE = 5'h04;
  localparam logic [4:0]  REG_PARTNER   = 5'h05;
  localparam int CTL_SOFT_RESET = 15;
  localparam int CTL_LOOPBACK   = 14;
  localparam int CTL_SPEED_LO   = 13;
  localparam int CTL_NEG_ENABLE = 12;
  localparam int CTL_POWER_DOWN = 11;
  localparam int CTL_ISOLATE    = 10;
  localparam int CTL_NEG_RESTART = 9;
  localparam int CTL_DUPLEX     = 8;
  localparam int CTL_COL_TEST   = 7;
  localparam int CTL_SPEED_HI   = 6;
  localparam int STS_NEG_DONE   = 5;
  localparam int STS_REM_FAULT  = 4;
  localparam int STS_LINK       = 2;
  localparam int STS_JABBER     = 1;
  localparam logic [15:0] CTL_RESET_VAL = 16'h1140;
  localparam logic [15:0] CTL_WMASK     = 16'hFFC0;
  // constant status bits: abilities, extended status/capability, short frames
  localparam logic [15:0] STS_CONST     = 16'h7949;
  localparam logic [15:0] ADV_RESET_VAL = 16'h1DE1;
  localparam logic [15:0] ADV_WMASK     = 16'hBDFF;
  localparam logic [1:0]  OP_WRITE      = 2'b01;
  localparam logic [1:0]  OP_READ       = 2'b10;
  localparam int          SOFT_RESET_CYCLES = 4;
  localparam int          SRST_W        = 3;
  localparam int          MDC_MAX_KHZ   = 12500;
  localparam int          SYS_MHZ       = 100;
  typedef enum logic [2:0] {
    PBM_IDLE, PBM_START, PBM_HEAD, PBM_TA, PBM_DATA
  } pbm_state_e;
endpackage

//--- verif/pbm_bank_tb.sv
// self-checking bench for the management register bank
module pbm_bank_tb
  import pbm_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [15:0] OUI_H = 16'h3C71; // arbitrary value
  localparam logic [5:0]  OUI_L = 6'h15;    // arbitrary value
  localparam logic [5:0]  MDL   = 6'h2A;    // arbitrary value
  localparam logic [3:0]  REV   = 4'h6;     // arbitrary value
  logic        clk_sys, reset, clk_en, mdc, neg_done, remote_fault;
  logic        link_up, jabber, mac_tx_en, mdio_out, mdio_oe, col_out;
  logic        rx_oe, tx_en_eff, loopback, speed_100, speed_bad;
  logic        full_duplex, neg_enable, power_down, neg_restart, soft_reset;
  wire         mdio_line;
  logic [15:0] partner_word, adv_active, rdat;
  logic [1:0]  ta;
  int          failures = 0, tests_run = 0, cyc = 0;
  int          restarts = 0, sr_cyc = 0, sr0, r0;
  logic [15:0] ctl_tab [4] = '{16'h0000, 16'h213F, 16'h0040, 16'h1000};
  logic [3:0]  out_tab [4] = '{4'h0, 4'hA, 4'h4, 4'hB};

  pbm_bank #(.OUI_HIGH(OUI_H), .OUI_LOW(OUI_L), .MODEL(MDL),
    .REVISION(REV), .PHY_ADDR(5'h01)) dut (
    .clk_sys(clk_sys), .reset(reset), .clk_en(clk_en), .mdc(mdc),
    .mdio_in(mdio_line), .mdio_out(mdio_out), .mdio_oe(mdio_oe),
    .neg_done(neg_done), .remote_fault(remote_fault), .link_up(link_up),
    .jabber(jabber), .partner_word(partner_word), .mac_tx_en(mac_tx_en),
    .col_out(col_out), .rx_oe(rx_oe), .tx_en_eff(tx_en_eff),
    .loopback(loopback), .speed_100(speed_100), .speed_bad(speed_bad),
    .full_duplex(full_duplex), .neg_enable(neg_enable),
    .power_down(power_down), .neg_restart(neg_restart),
    .soft_reset(soft_reset), .adv_active(adv_active));
  pbm_mac_model #(.PHY(5'h01)) u_mac (.mdc(mdc), .mdio_line(mdio_line),
    .mdio_out(mdio_out), .mdio_oe(mdio_oe));

  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (neg_restart === 1'b1) restarts <= restarts + 1;
    if (soft_reset === 1'b1) sr_cyc <= sr_cyc + 1;
    if (cyc == 40000) begin
      failures++;
      report_and_stop();
    end
  end

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // read one register and check turnaround and data
  task automatic rchk(input int pre, input logic [4:0] rg,
                      input logic [15:0] exp);
    u_mac.rd(pre, rg, rdat, ta);
    chk({14'h0, ta}, 16'h0002);
    chk(rdat, exp);
  endtask

  initial begin
    reset = 1'b1;
    clk_en = 1'b1;
    neg_done = 1'b0;
    remote_fault = 1'b0;
    link_up = 1'b0;
    jabber = 1'b0;
    mac_tx_en = 1'b0;
    partner_word = 16'h8000;
    // reset must also see one mdc edge
    fork
      repeat (16) @(posedge clk_sys);
      u_mac.bit_c(1'b1, 1'b0);
    join
    reset <= 1'b0;
    rchk(32, REG_CONTROL, 16'h1140);
    rchk(32, REG_STATUS, 16'h7949);
    rchk(1, REG_STATUS, 16'h7949);
    rchk(32, REG_ID_HIGH, OUI_H);
    rchk(32, REG_ID_LOW, {OUI_L, MDL, REV});
    rchk(32, REG_ADVERTISE, 16'h1DE1);
    rchk(32, REG_PARTNER, 16'h8000);
    rchk(32, 5'h1F, 16'h0000);
    chk(16'(restarts), 16'h0001);
    $display("test defaults done");
    u_mac.wr(5'h1E, REG_CONTROL, 16'h0000);
    rchk(1, REG_CONTROL, 16'h1140);
    for (int i = 0; i < 4; i++) begin
      u_mac.wr(5'h01, REG_CONTROL, ctl_tab[i]);
      rchk(1, REG_CONTROL, ctl_tab[i] & 16'hFFC0);
      chk({12'h0, speed_100, speed_bad, full_duplex, neg_enable},
          {12'h0, out_tab[i]});
    end
    $display("test speed and duplex done");
    u_mac.wr(5'h01, REG_ADVERTISE, 16'h7FFF);
    rchk(32, REG_ADVERTISE, 16'h3DFF);
    chk(adv_active, 16'h1DE1);
    r0 = restarts;
    u_mac.wr(5'h01, REG_CONTROL, 16'h1200);
    chk(adv_active, 16'h3DFF);
    chk({15'h0, restarts > r0}, 16'h0001);
    rchk(1, REG_CONTROL, 16'h1000);
    $display("test advertisement done");
    @(posedge clk_sys) mac_tx_en <= 1'b1;
    u_mac.wr(5'h01, REG_CONTROL, 16'h4080);
    chk({13'h0, loopback, col_out, rx_oe}, 16'h0007);
    u_mac.wr(5'h01, REG_CONTROL, 16'h0480);
    chk({13'h0, col_out, rx_oe, tx_en_eff}, 16'h0000);
    sr0 = sr_cyc;
    r0 = restarts;
    u_mac.wr(5'h01, REG_CONTROL, 16'hB580);
    chk(16'(sr_cyc - sr0), 16'(SOFT_RESET_CYCLES));
    chk({15'h0, restarts > r0}, 16'h0001);
    rchk(1, REG_CONTROL, 16'h3100);
    $display("test soft reset done");
    u_mac.wr(5'h01, REG_CONTROL, 16'h0800);
    chk({15'h0, power_down}, 16'h0001);
    sr0 = sr_cyc;
    r0 = restarts;
    u_mac.wr(5'h01, REG_CONTROL, 16'h0000);
    chk(16'(sr_cyc - sr0), 16'(SOFT_RESET_CYCLES));
    chk({15'h0, restarts > r0}, 16'h0001);
    $display("test power down done");
    @(posedge clk_sys) link_up <= 1'b1;
    rchk(1, REG_STATUS, 16'h7949);
    rchk(1, REG_STATUS, 16'h794D);
    @(posedge clk_sys) begin
      link_up <= 1'b0;
      remote_fault <= 1'b1;
      jabber <= 1'b1;
      neg_done <= 1'b1;
    end
    repeat (3) @(posedge clk_sys);
    link_up <= 1'b1;
    remote_fault <= 1'b0;
    jabber <= 1'b0;
    rchk(1, REG_STATUS, 16'h797B);
    rchk(1, REG_STATUS, 16'h796D);
    $display("test status latches done");
    report_and_stop();
  end
endmodule

//--- verif/pbm_mac_model.sv
// station management master model driving the serial management port
module pbm_mac_model
  import pbm_pkg::*;
#(
  parameter int         HALF = 4,
  parameter logic [4:0] PHY  = 5'h01
)(
  output logic      mdc,
  output wire       mdio_line,
  input  wire logic mdio_out,
  input  wire logic mdio_oe
);
  timeunit 1ns;
  timeprecision 1ps;
  logic base;
  logic mdo;
  logic moe;
  logic smp;
  // 12 ns base clock; mdc is divided from it and stands still between frames
  initial begin
    base = 1'b0;
    #3;
    forever #6 base = ~base;
  end
  initial begin
    mdc = 1'b0;
    mdo = 1'b1;
    moe = 1'b0;
    smp = 1'b1;
  end
  // pulled-up line: released by both ends it reads 1
  assign mdio_line = mdio_oe ? mdio_out : (moe ? mdo : 1'b1);
  // one bit cell of 96 ns: drive after the fall, sample at the rise
  task automatic bit_c(input logic b, input logic oe);
    mdo = b;
    moe = oe;
    repeat (HALF) @(posedge base);
    mdc = 1'b1;
    smp = mdio_line;
    repeat (HALF) @(posedge base);
    mdc = 1'b0;
  endtask
  task automatic head(input int pre, input logic [1:0] op,
                      input logic [4:0] phy, input logic [4:0] rg);
    logic [13:0] h;
    h = {2'b01, op, phy, rg};
    repeat (pre) bit_c(1'b1, 1'b1);
    for (int i = 13; i >= 0; i--) bit_c(h[i], 1'b1);
  endtask
  task automatic wr(input logic [4:0] phy, input logic [4:0] rg,
                    input logic [15:0] d);
    logic [17:0] w;
    w = {2'b10, d};
    head(32, OP_WRITE, phy, rg);
    for (int i = 17; i >= 0; i--) bit_c(w[i], 1'b1);
    bit_c(1'b1, 1'b0);
  endtask
  task automatic rd(input int pre, input logic [4:0] rg,
                    output logic [15:0] d, output logic [1:0] ta);
    head(pre, OP_READ, PHY, rg);
    bit_c(1'b1, 1'b0);
    ta[1] = smp;
    bit_c(1'b1, 1'b0);
    ta[0] = smp;
    for (int i = 15; i >= 0; i--) begin
      bit_c(1'b1, 1'b0);
      d[i] = smp;
    end
    bit_c(1'b1, 1'b0);
  endtask
endmodule
